// ===== hdl/blink_timer.v
// Purpose: frame-based blink phase generator
// Assumes: frameTick is a one-cycle pulse per frame
// Notes:   phase toggles after the coded frame count
`include "lcd_ext_consts.vh"
`default_nettype none
module blink_timer (
   input  wire       clk,
   input  wire       rstn,
   input  wire       frameTick,
   input  wire [2:0] blinkCode,
   output reg        blinkPhase
);
   reg  [6:0] frameCount;
   reg  [6:0] frameLimit;

   // ----------------------------------------------------------
   // Code to frames
   // ----------------------------------------------------------
   always @* begin
      case (blinkCode)
         3'h0:    frameLimit = `BLINK_F0;
         3'h1:    frameLimit = `BLINK_F1;
         3'h2:    frameLimit = `BLINK_F2;
         3'h3:    frameLimit = `BLINK_F3;
         3'h4:    frameLimit = `BLINK_F4;
         3'h5:    frameLimit = `BLINK_F5;
         3'h6:    frameLimit = `BLINK_F6;
         default: frameLimit = `BLINK_F7;
      endcase
   end

   // ----------------------------------------------------------
   // Frame counter
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         frameCount <= 7'h00;
         blinkPhase <= 1'b0;
      end else if (frameTick) begin
         if (frameCount + 7'h01 >= frameLimit) begin
            frameCount <= 7'h00;
            blinkPhase <= ~blinkPhase;
         end else
            frameCount <= frameCount + 7'h01;
      end
   end
endmodule // blink_timer
`default_nettype wire

// ===== hdl/lcd_ctrl_ext_commands.v
// Purpose: decode and execute extended LCD controller commands
// Assumes: host strobes are synchronous one-cycle pulses
// Notes:   display memory reached by a one-cycle read/write port
`include "lcd_ext_consts.vh"
`default_nettype none
module lcd_ctrl_ext_commands #(
   parameter [1:0] DEFAULT_MAP = 2'h0
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        cmdWr,
   input  wire        dataWr,
   input  wire [7:0]  dataIn,
   input  wire [15:0] addrPointer,
   input  wire        dataAccessDone,
   input  wire        dataAccessDec,
   input  wire [15:0] cursorLoad,
   input  wire        cursorLoadWr,
   input  wire        frameTick,
   input  wire        pixelIn,
   input  wire [3:0]  attrIn,
   input  wire [7:0]  memRdData,
   output reg  [15:0] memAddr,
   output reg         memRd,
   output reg         memWr,
   output reg  [7:0]  memWrData,
   output reg         busy,
   output reg         screenReverse,
   output reg  [2:0]  blinkCode,
   output reg         cursorAutoMove,
   output reg  [1:0]  fontCode,
   output reg  [1:0]  charMapSel,
   output reg  [15:0] cursorPointer,
   output reg         pixelOut,
   output wire        blinkPhase
);
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_READ  = 2'h1;
   localparam [1:0] ST_WRITE = 2'h2;

   reg  [1:0]  state;
   reg  [2:0]  bitIndex;
   reg         bitValue;
   reg  [7:0]  bitMask;
   wire [7:0]  firstParamByte;
   wire        clearParams;
   wire        isBitCmd;

   assign isBitCmd    = (dataIn[7:4] == `CMD_BIT_HI);
   assign clearParams = cmdWr;

   // ----------------------------------------------------------
   // Parameter bytes
   // ----------------------------------------------------------
   param_capture uParams (
      .clk             (clk),
      .rstn            (rstn),
      .dataWr          (dataWr),
      .dataIn          (dataIn),
      .clearParams     (clearParams),
      .firstParamByte  (firstParamByte),
      .secondParamByte (),
      .paramCount      ()
   );

   // ----------------------------------------------------------
   // Blink time base
   // ----------------------------------------------------------
   blink_timer uBlink (
      .clk        (clk),
      .rstn       (rstn),
      .frameTick  (frameTick),
      .blinkCode  (blinkCode),
      .blinkPhase (blinkPhase)
   );

   // ----------------------------------------------------------
   // Setting commands
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         screenReverse  <= 1'b0;
         blinkCode      <= `BLINK_RST;
         cursorAutoMove <= 1'b0;
         fontCode       <= `FONT_RST;
      end else if (cmdWr && !busy) begin
         case (dataIn)
            `CMD_REVERSE:
               screenReverse <= firstParamByte[`REVERSE_POS];
            `CMD_BLINK_TIME:
               blinkCode <= firstParamByte[2:0];
            `CMD_AUTO_MOVE:
               cursorAutoMove <= firstParamByte[`AUTO_MOVE_POS];
            `CMD_FONT_SEL:
               fontCode <= firstParamByte[1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Character map selection
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn)
         charMapSel <= 2'h0;
      else if (fontCode[1])
         charMapSel <= {1'b1, fontCode[0]};
      else
         charMapSel <= DEFAULT_MAP;
   end

   // ----------------------------------------------------------
   // Cursor auto move
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn)
         cursorPointer <= 16'h0000;
      else if (cursorLoadWr)
         cursorPointer <= cursorLoad;
      else if (dataAccessDone && cursorAutoMove) begin
         if (dataAccessDec)
            cursorPointer <= cursorPointer - 16'h0001;
         else
            cursorPointer <= cursorPointer + 16'h0001;
      end
   end

   // ----------------------------------------------------------
   // Pixel output
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn)
         pixelOut <= 1'b0;
      else if (attrIn[3] && blinkPhase)
         pixelOut <= screenReverse;
      else
         pixelOut <= pixelIn ^ screenReverse;
   end

   // ----------------------------------------------------------
   // Bit set/reset read-modify-write
   // ----------------------------------------------------------
   always @* begin
      bitMask = 8'h01 << bitIndex;
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state     <= ST_IDLE;
         bitIndex  <= 3'h0;
         bitValue  <= 1'b0;
         memAddr   <= 16'h0000;
         memRd     <= 1'b0;
         memWr     <= 1'b0;
         memWrData <= 8'h00;
         busy      <= 1'b0;
      end else begin
         memRd <= 1'b0;
         memWr <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (cmdWr && isBitCmd) begin
                  bitIndex <= dataIn[2:0];
                  bitValue <= dataIn[`BIT_SET_POS];
                  memAddr  <= addrPointer;
                  memRd    <= 1'b1;
                  busy     <= 1'b1;
                  state    <= ST_READ;
               end
            end
            ST_READ: begin
               if (bitValue)
                  memWrData <= memRdData | bitMask;
               else
                  memWrData <= memRdData & ~bitMask;
               memWr <= 1'b1;
               state <= ST_WRITE;
            end
            ST_WRITE: begin
               busy  <= 1'b0;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule // lcd_ctrl_ext_commands
`default_nettype wire

// ===== hdl/param_capture.v
// Purpose: holds the two most recent parameter bytes
// Assumes: one-cycle write strobe, same clock domain
// Notes:   oldest byte is first_param_byte
`default_nettype none
module param_capture (
   input  wire       clk,
   input  wire       rstn,
   input  wire       dataWr,
   input  wire [7:0] dataIn,
   input  wire       clearParams,
   output reg  [7:0] firstParamByte,
   output reg  [7:0] secondParamByte,
   output reg  [1:0] paramCount
);
   // ----------------------------------------------------------
   // Parameter shift
   // ----------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn || clearParams) begin
         firstParamByte  <= 8'h00;
         secondParamByte <= 8'h00;
         paramCount      <= 2'h0;
      end else if (dataWr) begin
         if (paramCount == 2'h0) begin
            firstParamByte <= dataIn;
            paramCount     <= 2'h1;
         end else begin
            if (paramCount == 2'h1)
               secondParamByte <= dataIn;
            else begin
               firstParamByte  <= secondParamByte;
               secondParamByte <= dataIn;
            end
            paramCount <= 2'h2;
         end
      end
   end
endmodule // param_capture
`default_nettype wire

// ===== inc/lcd_ext_consts.vh
// Purpose: constants for the extended LCD command block
// Assumes: 100 MHz clock
// Notes:   opcodes, field positions, blink frame counts
`ifndef LCD_EXT_CONSTS_VH
`define LCD_EXT_CONSTS_VH

// ----------------------------------------------------------
// Command codes
// ----------------------------------------------------------
`define CMD_BIT_HI      4'hf
`define CMD_REVERSE     8'hd0
`define CMD_BLINK_TIME  8'h50
`define CMD_AUTO_MOVE   8'h60
`define CMD_FONT_SEL    8'h70

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define BIT_SET_POS     3
`define REVERSE_POS     0
`define AUTO_MOVE_POS   0

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define BLINK_RST       3'h0
`define FONT_RST        2'h0

// ----------------------------------------------------------
// Blink frame counts per code
// ----------------------------------------------------------
`define BLINK_F0        7'h04
`define BLINK_F1        7'h0f
`define BLINK_F2        7'h1e
`define BLINK_F3        7'h2d
`define BLINK_F4        7'h3c
`define BLINK_F5        7'h4b
`define BLINK_F6        7'h5a
`define BLINK_F7        7'h78

`endif

// ===== test/disp_mem_model.sv
// Purpose: display memory behind the command block
// Assumes: read data wanted in the read cycle or the one after
// Notes:   shows inverted junk when no read is live
`default_nettype none
module disp_mem_model (
   input  wire logic        clk,
   input  wire logic        memRd,
   input  wire logic        memWr,
   input  wire logic [15:0] memAddr,
   input  wire logic [7:0]  memWrData,
   output var  logic [7:0]  memRdData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [7:0] held = 8'h00;
   logic       live = 1'h0;
   always @(posedge clk) begin
      if (memWr) mem[memAddr] <= memWrData;
      live <= memRd;
      if (memRd) held <= mem[memAddr];
   end
   always_comb memRdData = memRd ? mem[memAddr] : (live ? held : ~held);
endmodule // disp_mem_model
`default_nettype wire

// ===== test/lcd_ctrl_ext_commands_tb.sv
// Purpose: self-checking bench for the extended command block
// Assumes: display memory model on the memory port
// Notes:   blink checks first, then settings rows, then hand tests
`default_nettype none
module lcd_ctrl_ext_commands_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int n; logic [7:0] p1, p2, p3, cmd; logic [8:0] exp;} row_t;
   row_t rows [11] = '{'{1, 8'hff, 8'h00, 8'h00, 8'hd0, 9'h100},
      '{2, 8'hff, 8'h00, 8'h00, 8'h50, 9'h1e0},
      '{3, 8'h07, 8'hfa, 8'hff, 8'h50, 9'h140},
      '{2, 8'hff, 8'hff, 8'h00, 8'h51, 9'h140},
      '{2, 8'h01, 8'h00, 8'h00, 8'h60, 9'h150},
      '{2, 8'hfe, 8'h01, 8'h00, 8'h60, 9'h140},
      '{2, 8'hfe, 8'hff, 8'h00, 8'h70, 9'h14a},
      '{2, 8'h03, 8'h00, 8'h00, 8'h70, 9'h14f},
      '{2, 8'h01, 8'h00, 8'h00, 8'h70, 9'h144},
      '{1, 8'hfe, 8'h00, 8'h00, 8'hd0, 9'h044},
      '{2, 8'h00, 8'hff, 8'h00, 8'h70, 9'h040}};
   logic clk = 1'h0, rstn = 1'h0, cmdWr = 1'h0, dataWr = 1'h0;
   logic dataAccessDone = 1'h0, dataAccessDec = 1'h0, cursorLoadWr = 1'h0;
   logic frameTick = 1'h0, pixelIn = 1'h0;
   logic [7:0]  dataIn = 8'h00, exp;
   logic [15:0] addrPointer = 16'h0000, cursorLoad = 16'h0000;
   logic [3:0]  attrIn = 4'h0;
   wire logic [15:0] memAddr, cursorPointer;
   wire logic [7:0]  memWrData, memRdData;
   wire logic [2:0]  blinkCode;
   wire logic [1:0]  fontCode, charMapSel;
   wire logic memRd, memWr, busy, screenReverse, cursorAutoMove, pixelOut;
   wire logic blinkPhase;
   wire logic [8:0] cfg = {screenReverse, blinkCode, cursorAutoMove,
                           fontCode, charMapSel};
   int checked = 0, miscompares = 0;
   lcd_ctrl_ext_commands #(.DEFAULT_MAP(2'h0)) dut (.*);
   disp_mem_model ram (.*);
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] got, want);
      checked++;
      if (got !== want) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic stop_test;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic idle;
      @(posedge clk);
      cmdWr <= 1'h0;
      dataWr <= 1'h0;
      frameTick <= 1'h0;
      dataAccessDone <= 1'h0;
      cursorLoadWr <= 1'h0;
      #1;
   endtask
   task automatic put(input logic c, input logic [7:0] d);
      @(posedge clk);
      cmdWr <= c;
      dataWr <= !c;
      dataIn <= d;
   endtask
   task automatic tick;
      @(posedge clk);
      frameTick <= 1'h1;
      idle;
   endtask
   task automatic acc(input logic dec);
      @(posedge clk);
      dataAccessDone <= 1'h1;
      dataAccessDec <= dec;
      idle;
      idle;
   endtask
   task automatic bitOp(input logic [7:0] c);
      put(1'h1, c);
      idle;
      for (int i = 0; i < 8 && busy !== 1'h0; i++) idle;
      if (busy !== 1'h0) begin
         miscompares++;
         stop_test;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) tick;
      idle;
      chk(blinkPhase, 16'h0);
      tick;
      idle;
      chk(blinkPhase, 16'h1);
      @(posedge clk);
      attrIn <= 4'h8;
      pixelIn <= 1'h1;
      idle;
      idle;
      chk(pixelOut, 16'h0);
      $display("blink done");
      foreach (rows[r]) begin
         put(1'h0, rows[r].p1);
         if (rows[r].n > 1) put(1'h0, rows[r].p2);
         if (rows[r].n > 2) put(1'h0, rows[r].p3);
         put(1'h1, rows[r].cmd);
         idle;
         idle;
         chk(cfg, rows[r].exp);
         $display("row %0d done", r);
      end
      @(posedge clk);
      addrPointer <= 16'h0123;
      attrIn <= 4'h0;
      ram.mem[16'h0123] = 8'ha5;
      exp = 8'ha5;
      for (int k = 0; k < 16; k++) begin
         bitOp(8'hf0 | k[7:0]);
         exp = k[3] ? exp | (8'h01 << k[2:0]) : exp & ~(8'h01 << k[2:0]);
         chk(ram.mem[16'h0123], exp);
      end
      put(1'h1, 8'hf8);
      bitOp(8'hf0);
      chk(ram.mem[16'h0123], exp | 8'h01);
      $display("bit ops done");
      put(1'h0, 8'h01);
      put(1'h1, 8'hd0);
      idle;
      idle;
      chk(pixelOut, 16'h0);
      @(posedge clk);
      cursorLoadWr <= 1'h1;
      idle;
      acc(1'h0);
      chk(cursorPointer, 16'h0000);
      put(1'h0, 8'h01);
      put(1'h0, 8'h00);
      put(1'h1, 8'h60);
      idle;
      acc(1'h1);
      chk(cursorPointer, 16'hffff);
      acc(1'h0);
      chk(cursorPointer, 16'h0000);
      $display("reverse and cursor done");
      @(posedge clk);
      rstn <= 1'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      idle;
      chk(cfg, 16'h0000);
      $display("reset done");
      stop_test;
   end
endmodule // lcd_ctrl_ext_commands_tb
`default_nettype wire

// ===== test/lcd_ext_monitor.sv
// Purpose: port assertions for the extended command block
// Assumes: single clock, sync active-low reset
// Notes:   bound below the module
`default_nettype none
module lcd_ext_monitor (
   input wire logic        clk, rstn, cmdWr, busy, memRd, memWr,
   input wire logic        screenReverse, dataAccessDone, dataAccessDec,
   input wire logic        cursorAutoMove, cursorLoadWr, pixelIn,
   input wire logic        pixelOut, blinkPhase,
   input wire logic [7:0]  dataIn, memWrData, memRdData,
   input wire logic [15:0] memAddr, addrPointer, cursorPointer,
   input wire logic [3:0]  attrIn,
   input wire logic [2:0]  blinkCode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire bitCmd = cmdWr && !busy && dataIn[7:4] == 4'hf;
   function automatic logic [7:0] op(input logic [7:0] d, c);
      op = c[3] ? d | (8'h01 << c[2:0]) : d & ~(8'h01 << c[2:0]);
   endfunction
   bit_read_a: assert property (bitCmd |=>
      memRd && busy && memAddr == $past(addrPointer)) else $error("read");
   bit_write_a: assert property (memWr |->
      memWrData == op($past(memRdData), $past(dataIn, 2))) else $error("wr");
   busy_span_a: assert property (bitCmd |=> busy [*2] ##1 !busy)
      else $error("busy");
   rev_hold_a: assert property ($changed(screenReverse) |->
      $past(cmdWr && dataIn == 8'hd0)) else $error("reverse");
   blink_hold_a: assert property ($changed(blinkCode) |->
      $past(cmdWr && dataIn == 8'h50)) else $error("blink code");
   cursor_step_a: assert property (dataAccessDone && cursorAutoMove &&
      !cursorLoadWr |=> cursorPointer == $past(cursorPointer) +
      ($past(dataAccessDec) ? 16'hffff : 16'h0001)) else $error("cursor");
   pixel_rev_a: assert property (!attrIn[3] && !cmdWr |=>
      pixelOut == $past(pixelIn ^ screenReverse)) else $error("pixel");
   blink_blank_a: assert property (attrIn[3] && blinkPhase && !cmdWr |=>
      pixelOut == $past(screenReverse)) else $error("blank");
   cover property (bitCmd);
   cover property (dataAccessDone && cursorAutoMove);
   cover property ($rose(screenReverse));
endmodule // lcd_ext_monitor
bind lcd_ctrl_ext_commands lcd_ext_monitor mon (.*);
`default_nettype wire
